// [rtl/psp_regs.svh]
`ifndef PSP_REGS_SVH
`define PSP_REGS_SVH
// Register offsets (byte addresses, one word each)
`define PSP_OFF_CTRL      8'h00
`define PSP_OFF_STATUS    8'h04
`define PSP_OFF_IRQ_STAT  8'h08
`define PSP_OFF_IRQ_MASK  8'h0c
`define PSP_OFF_POWER     8'h10
`define PSP_OFF_PDP       8'h14
// CTRL fields
`define PSP_CTRL_STANDBY_BIT 0
`define PSP_CTRL_DBCLR_BIT   1
`define PSP_CTRL_RESET       8'h00
// Interrupt bit positions
`define PSP_IRQ_MISMATCH  0
`define PSP_IRQ_STATE     1
`define PSP_IRQ_THERMAL   2
`define PSP_IRQ_FAULT     3
`define PSP_IRQ_W         4
// Idle timeout T, in microseconds, and derived cycles at 100 MHz
`define PSP_IDLE_T_US     100
`define PSP_CLK_MHZ       100
`define PSP_IDLE_CYCLES   (`PSP_IDLE_T_US * `PSP_CLK_MHZ)
`endif

// [rtl/psp_pkg.sv]
package psp_pkg;
    typedef enum logic [1:0] {
        PSP_ACTIVE,
        PSP_IDLE,
        PSP_STANDBY,
        PSP_SLEEP
    } psp_state_t;

    // Decoded strap configuration, volts in 0.1 V and amps in 0.1 A steps
    typedef struct packed {
        logic [7:0] vmin_dv;
        logic [7:0] vmax_dv;
        logic [5:0] iop_da;
        logic [5:0] imax_da;
    } psp_cfg_t;

    // Best source offer of the current capability message
    typedef struct packed {
        logic       valid;
        logic [7:0] volt_dv;
        logic [5:0] curr_da;
    } psp_offer_t;

    // Activity sources that keep the device awake
    typedef struct packed {
        logic pd_msg;
        logic cc_change;
        logic gpio_event;
        logic i2c_txn;
        logic volt_alert;
        logic fault_alert;
    } psp_act_t;
endpackage

// [rtl/psp_sink_policy.sv]
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`include "psp_regs.svh"
// How it works
// - Minimum power is operating current times minimum volts
// - Offer power below minimum sets mismatch flag
// - Report min, operational, maximum PDP from configuration; no operational PDP is reported, the PDP register holds the maximum twice
// - One of active, idle or sleep, automatic
// - Leave active after quiet interval T
// - Sleep still detects cable attach
// - Standby is idle variant; path and CC per state
// - Over-temperature disables all but supervision; vin_switch_enable and capability_mismatch_out are not gated by it
// - Resume only below threshold minus hysteresis
// - 3.3 V switch needs supply and cleared dead-battery
// - Contracts at 5..20 V up to 5 A
// - Min-voltage strap 0..4 maps 5..20 V
// - Max-voltage strap 1,3,5,7 maps 9..20 V
// - No offer inside voltage range sets mismatch
// - Zero operating current never mismatches on current
module psp_sink_policy
    import psp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [2:0]  min_voltage_strap,
    input  wire logic [2:0]  max_voltage_strap,
    input  wire logic [2:0]  operating_current_strap,
    input  wire logic [2:0]  maximum_current_strap,
    input  wire psp_offer_t  src_offer,
    input  wire logic        src_caps_strobe,
    input  wire psp_act_t    activity,
    input  wire logic        cc_attached,
    input  wire logic        cc_flipped,
    input  wire logic        cc_debug,
    input  wire logic        temp_above_threshold,
    input  wire logic        temp_below_hysteresis,
    input  wire logic        main_3v3_supply_input,
    input  wire logic        fault_in,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    output logic             irq,
    output logic             internal_power_path,
    output logic             external_fet_power_path,
    output logic             cc1_rp_enable,
    output logic             cc2_rp_enable,
    output logic             attach_indicator,
    output logic             orientation_indicator,
    output logic             debug_accessory_indicator,
    output logic             capability_mismatch_out,
    output logic             vin_switch_enable,
    output logic             shutdown_active,
    output psp_state_t       power_state,
    output logic [15:0]      min_power_cw
);

    ////////////////////////////////////////////////////////////////////////
    // Strap decoding and power arithmetic

    // Volts in 0.1 V units; reserved codes fall back to 5 V so the range stays sane
    function automatic logic [7:0] min_volt(input logic [2:0] code);
        logic [7:0] v;
        v = 8'h32;
        case (code)
            3'h0: v = 8'h32;
            3'h1: v = 8'h5a;
            3'h2: v = 8'h78;
            3'h3: v = 8'h96;
            3'h4: v = 8'hc8;
            default: v = 8'h32;
        endcase
        return v;
    endfunction

    // Bit 0 of the code is ignored, so an even code reads as the odd code above it
    function automatic logic [7:0] max_volt(input logic [2:0] code);
        logic [7:0] v;
        v = 8'h5a;
        case (code)
            3'h0, 3'h1: v = 8'h5a;
            3'h2, 3'h3: v = 8'h78;
            3'h4, 3'h5: v = 8'h96;
            default:    v = 8'hc8;
        endcase
        return v;
    endfunction

    // Operating current steps of 1 A per code, plus 0.5 A from bit 2 of the maximum-current code
    function automatic logic [5:0] op_curr(input logic [2:0] a3, input logic [2:0] a4);
        logic [5:0] base;
        base = 6'({a3, 1'b0}) * 6'h05;
        return base + (a4[2] ? 6'h05 : 6'h00);
    endfunction

    function automatic logic [5:0] max_curr(input logic [2:0] a4);
        logic [5:0] i;
        i = 6'h0f;
        case (a4[1:0])
            2'h0: i = 6'h0f;
            2'h1: i = 6'h1e;
            2'h2: i = 6'h28;
            default: i = 6'h32;
        endcase
        return i;
    endfunction

    // Power in centiwatts from 0.1 V and 0.1 A units; used for all PDP figures
    function automatic logic [15:0] power_cw(input logic [7:0] v, input logic [5:0] i);
        return 16'(v * i);
    endfunction

    psp_cfg_t    cfg;
    logic [15:0] pdp_min_cw;
    logic [15:0] pdp_max_cw;
    logic [15:0] offer_cw;

    always_comb begin
        cfg.vmin_dv = min_volt(min_voltage_strap);
        cfg.vmax_dv = max_volt(max_voltage_strap);
        cfg.iop_da  = op_curr(operating_current_strap, maximum_current_strap);
        cfg.imax_da = max_curr(maximum_current_strap);
    end

    assign pdp_min_cw = power_cw(cfg.vmin_dv, cfg.imax_da);
    assign pdp_max_cw = power_cw(cfg.vmax_dv, cfg.imax_da);
    assign offer_cw   = power_cw(src_offer.volt_dv, src_offer.curr_da);

    ////////////////////////////////////////////////////////////////////////
    // Capability mismatch evaluation on each source capability message

    logic        mismatch_r, mismatch_nxt;
    logic [15:0] min_pwr_r, min_pwr_nxt;
    logic        mis_volt, mis_pwr;

    always_comb begin
        mis_volt     = !src_offer.valid || src_offer.volt_dv < cfg.vmin_dv
                       || src_offer.volt_dv > cfg.vmax_dv;
        mis_pwr      = cfg.iop_da != 6'h00 && offer_cw < min_pwr_r;
        min_pwr_nxt  = power_cw(cfg.vmin_dv, cfg.iop_da);
        mismatch_nxt = mismatch_r;
        if (!cc_attached) begin
            mismatch_nxt = 1'b0;
        end else if (src_caps_strobe) begin
            mismatch_nxt = mis_volt || mis_pwr;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mismatch_r <= 1'b0;
            min_pwr_r  <= 16'h0000;
        end else begin
            mismatch_r <= mismatch_nxt;
            min_pwr_r  <= min_pwr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Thermal shutdown with hysteresis

    logic therm_r, therm_nxt;

    always_comb begin
        therm_nxt = therm_r;
        if (temp_above_threshold) begin
            therm_nxt = 1'b1;
        end else if (therm_r && temp_below_hysteresis) begin
            therm_nxt = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power state machine with idle timer

    psp_state_t  state_r, state_nxt;
    logic [15:0] idle_cnt_r, idle_cnt_nxt;
    logic        any_act;
    logic        standby_req;

    assign any_act = |activity;

    always_comb begin
        state_nxt    = state_r;
        idle_cnt_nxt = idle_cnt_r;
        case (state_r)
            PSP_ACTIVE: begin
                if (any_act) begin
                    idle_cnt_nxt = 16'h0000;
                end else if (idle_cnt_r == 16'(`PSP_IDLE_CYCLES - 1)) begin
                    idle_cnt_nxt = 16'h0000;
                    state_nxt    = PSP_IDLE;
                end else begin
                    idle_cnt_nxt = idle_cnt_r + 16'h0001;
                end
            end
            PSP_IDLE, PSP_STANDBY: begin
                if (any_act) begin
                    state_nxt = PSP_ACTIVE;
                end else if (!cc_attached) begin
                    state_nxt = PSP_SLEEP;
                end else if (standby_req) begin
                    state_nxt = PSP_STANDBY;
                end else begin
                    state_nxt = PSP_IDLE;
                end
            end
            default: begin
                // Cable detection stays alive so an attach wakes the part
                if (any_act || cc_attached) begin
                    state_nxt = PSP_ACTIVE;
                end
            end
        endcase
        if (therm_r) begin
            state_nxt    = PSP_SLEEP;
            idle_cnt_nxt = 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r    <= PSP_ACTIVE;
            idle_cnt_r <= 16'h0000;
            therm_r    <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            idle_cnt_r <= idle_cnt_nxt;
            therm_r    <= therm_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file and interrupts

    logic [7:0]           ctrl_r, ctrl_nxt;
    logic [`PSP_IRQ_W-1:0] ist_r, ist_nxt;
    logic [`PSP_IRQ_W-1:0] imask_r, imask_nxt;
    logic [31:0]          rdata_r, rdata_nxt;
    logic [`PSP_IRQ_W-1:0] evt;

    assign standby_req = ctrl_r[`PSP_CTRL_STANDBY_BIT];

    always_comb begin
        evt = '0;
        evt[`PSP_IRQ_MISMATCH] = mismatch_nxt && !mismatch_r;
        evt[`PSP_IRQ_STATE]    = state_nxt != state_r;
        evt[`PSP_IRQ_THERMAL]  = therm_nxt && !therm_r;
        evt[`PSP_IRQ_FAULT]    = fault_in;
    end

    // Set beats clear so an event in the clearing cycle survives
    always_comb begin
        ctrl_nxt  = ctrl_r;
        imask_nxt = imask_r;
        ist_nxt   = ist_r;
        rdata_nxt = 32'h0000_0000;
        if (reg_wr) begin
            if (reg_addr == `PSP_OFF_CTRL) begin
                ctrl_nxt = reg_wdata[7:0];
            end else if (reg_addr == `PSP_OFF_IRQ_STAT) begin
                ist_nxt = ist_r & ~reg_wdata[`PSP_IRQ_W-1:0];
            end else if (reg_addr == `PSP_OFF_IRQ_MASK) begin
                imask_nxt = reg_wdata[`PSP_IRQ_W-1:0];
            end
        end
        ist_nxt = ist_nxt | evt;
        if (reg_rd) begin
            if (reg_addr == `PSP_OFF_CTRL) begin
                rdata_nxt = {24'h000000, ctrl_r};
            end else if (reg_addr == `PSP_OFF_STATUS) begin
                rdata_nxt = {24'h000000, state_r, therm_r, vin_switch_enable, mismatch_r,
                             cc_debug, cc_flipped, cc_attached};
            end else if (reg_addr == `PSP_OFF_IRQ_STAT) begin
                rdata_nxt = {28'h0000000, ist_r};
            end else if (reg_addr == `PSP_OFF_IRQ_MASK) begin
                rdata_nxt = {28'h0000000, imask_r};
            end else if (reg_addr == `PSP_OFF_POWER) begin
                rdata_nxt = {min_pwr_r, pdp_min_cw};
            end else if (reg_addr == `PSP_OFF_PDP) begin
                rdata_nxt = {pdp_max_cw, pdp_max_cw};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_r    <= `PSP_CTRL_RESET;
            ist_r     <= '0;
            imask_r   <= '0;
            rdata_r   <= 32'h0000_0000;
        end else begin
            ctrl_r    <= ctrl_nxt;
            ist_r     <= ist_nxt;
            imask_r   <= imask_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    logic path_on;

    // Path open in standby/sleep, on fault and in thermal shutdown
    assign path_on = (state_r == PSP_ACTIVE || state_r == PSP_IDLE)
                     && cc_attached && !fault_in && !therm_r;

    assign reg_rdata                 = rdata_r;
    assign irq                       = |(ist_r & imask_r);
    assign internal_power_path       = path_on;
    assign external_fet_power_path   = path_on;
    assign cc1_rp_enable             = (state_r == PSP_ACTIVE || state_r == PSP_IDLE) && !therm_r;
    assign cc2_rp_enable             = 1'b0;
    assign attach_indicator          = cc_attached && !therm_r;
    assign orientation_indicator     = cc_attached && cc_flipped && !therm_r;
    assign debug_accessory_indicator = cc_debug && !therm_r;
    assign capability_mismatch_out   = mismatch_r;
    assign vin_switch_enable         = main_3v3_supply_input && ctrl_r[`PSP_CTRL_DBCLR_BIT];
    assign shutdown_active           = therm_r;
    assign power_state               = state_r;
    assign min_power_cw              = min_pwr_r;

endmodule

// [dv/psp_sva.sv]
`timescale 1ns/100ps
module psp_sva
    import psp_pkg::*;
(
    input wire logic       clk,
    input wire logic       srst,
    input wire psp_act_t   activity,
    input wire logic       cc_attached,
    input wire logic       temp_above_threshold,
    input wire logic       temp_below_hysteresis,
    input wire logic       main_3v3_supply_input,
    input wire logic       fault_in,
    input wire logic       internal_power_path,
    input wire logic       cc1_rp_enable,
    input wire logic       cc2_rp_enable,
    input wire logic       attach_indicator,
    input wire logic       vin_switch_enable,
    input wire logic       shutdown_active,
    input wire psp_state_t power_state
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////
    // Wake causes; a pending thermal trip overrides every one of them
    sequence s_cool;
        !temp_above_threshold && !shutdown_active;
    endsequence
    sequence s_wake;
        |activity || (power_state == PSP_SLEEP && cc_attached);
    endsequence
    ////////////////////////////////////////////////////////////////////////
    // Path, termination, thermal and supply relations
    a_path_gated: assert property (internal_power_path |-> power_state inside {PSP_ACTIVE, PSP_IDLE}
        && cc_attached && !fault_in && !shutdown_active) else $error("power path on when barred");
    a_cc1_term: assert property (cc1_rp_enable == (power_state inside {PSP_ACTIVE, PSP_IDLE} && !shutdown_active))
        else $error("cc1 termination wrong for state");
    a_cc2_open: assert property (!cc2_rp_enable) else $error("cc2 termination not open");
    a_hot_entry: assert property (temp_above_threshold |=> shutdown_active) else $error("no shutdown when hot");
    a_hot_quiet: assert property (shutdown_active |-> !attach_indicator && !internal_power_path)
        else $error("function left on in shutdown");
    a_hot_hold: assert property (shutdown_active && !temp_below_hysteresis |=> shutdown_active)
        else $error("shutdown left before hysteresis");
    a_cool_exit: assert property (shutdown_active && temp_below_hysteresis && !temp_above_threshold
        |=> !shutdown_active) else $error("shutdown not released");
    a_vin_needs: assert property (vin_switch_enable |-> main_3v3_supply_input) else $error("3v3 switch without supply");
    a_wake_active: assert property (power_state != PSP_ACTIVE ##0 s_wake ##0 s_cool |=> power_state == PSP_ACTIVE)
        else $error("no wake on activity");
    a_busy_stays: assert property (power_state == PSP_ACTIVE && |activity ##0 s_cool |=> power_state == PSP_ACTIVE)
        else $error("left active while busy");
endmodule
bind psp_sink_policy psp_sva i_sva (.*);

// [dv/psp_src_model.sv]
`timescale 1ns/100ps
module psp_src_model
    import psp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       send,
    input  wire psp_offer_t offer,
    output psp_offer_t      src_offer = '0,
    output logic            src_caps_strobe = 1'h0
);
    ////////////////////////////////////////////////////////////////////////
    // Offer is qualified only by the strobe; between strobes it flips to its inverse every cycle, so off-strobe use shows up
    always_ff @(posedge clk) begin
        src_caps_strobe <= send;
        src_offer       <= send ? offer : ~src_offer;
    end
endmodule

// [dv/tb_top.sv]
`timescale 1ns/100ps
`include "psp_regs.svh"
module tb_top;
    import psp_pkg::*;
    logic        clk = 1'h0, srst = 1'h1, send = 1'h0, src_caps_strobe, irq;
    logic [2:0]  min_voltage_strap = '0, max_voltage_strap = 3'h1, operating_current_strap = '0;
    logic [2:0]  maximum_current_strap = '0;
    psp_offer_t  src_offer, offer_in = '0, o;
    psp_act_t    activity = '0;
    logic        cc_attached = '0, cc_flipped = '0, cc_debug = '0, fault_in = '0, reg_wr = '0, reg_rd = '0;
    logic        temp_above_threshold = '0, temp_below_hysteresis = '0, main_3v3_supply_input = '0;
    logic        internal_power_path, external_fet_power_path, cc1_rp_enable, cc2_rp_enable;
    logic        attach_indicator, orientation_indicator, debug_accessory_indicator, capability_mismatch_out;
    logic        vin_switch_enable, shutdown_active;
    logic [7:0]  reg_addr = '0, ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h20};
    logic [7:0]  vtab [5] = '{8'h32, 8'h5a, 8'h78, 8'h96, 8'hc8};
    logic [31:0] reg_wdata = '0, reg_rdata;
    logic [15:0] min_power_cw;
    psp_state_t  power_state;
    int          fails = 0, check_count = 0, n;
    wire [3:0]   pathv = {internal_power_path, external_fet_power_path, cc1_rp_enable, cc2_rp_enable};
    psp_sink_policy i_dut (.*);
    psp_src_model   i_src (.clk(clk), .send(send), .offer(offer_in), .src_offer(src_offer),
                           .src_caps_strobe(src_caps_strobe));
    ////////////////////////////////////////////////////////////////////////
    // Expected figures in 0.1 V, 0.1 A and 0.01 W steps
    function automatic int vmin(input logic [2:0] c);
        return vtab[c > 3'h4 ? 3'h0 : c];
    endfunction
    function automatic int vmax(input logic [2:0] c);
        return vtab[int'(c) / 2 + 1];
    endfunction
    function automatic int iop(input logic [2:0] a, input logic [2:0] b);
        return a * 10 + (b[2] ? 5 : 0);
    endfunction
    function automatic int imax(input logic [2:0] b);
        int t [4] = '{15, 30, 40, 50};
        return t[b[1:0]];
    endfunction
    function automatic logic mis_exp(input psp_offer_t f);
        int vn = vmin(min_voltage_strap);
        int ip = iop(operating_current_strap, maximum_current_strap);
        return !f.valid || f.volt_dv < vn || f.volt_dv > vmax(max_voltage_strap)
               || (ip != 0 && f.volt_dv * f.curr_da < ip * vn);
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // Compare, bus and wait helpers; every task except chk and complete_run returns just after a rising edge
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %h expected %h", $time, w, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string w);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        @(negedge clk);
        chk(reg_rdata & m, e, w);
        @(posedge clk);
    endtask
    task automatic look(input logic [31:0] got, input logic [31:0] e, input string w);
        @(negedge clk);
        chk(got, e, w);
        @(posedge clk);
    endtask
    task automatic offer(input psp_offer_t f);
        offer_in <= f;
        send     <= 1'h1;
        @(posedge clk);
        send <= 1'h0;
        repeat (3) @(posedge clk);
        look(capability_mismatch_out, mis_exp(f), "mismatch");
    endtask
    task automatic wait_st(input psp_state_t s, input int lim);
        n = 0;
        while (power_state !== s && n < lim) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        check_count++;
        if (power_state !== s) begin
            fails++;
            $display("Error at %0t: state %0d not reached", $time, s);
            complete_run();
        end
    endtask
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Clock and a run limit, so a stuck design still reaches a verdict
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #1ms;
        fails++;
        $display("Error at %0t: run limit expired", $time);
        complete_run();
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'he977536f));
        repeat (12) @(posedge clk);
        srst <= 1'h0;
        @(posedge clk);
        wr(8'h20, '1);
        foreach (ra[i]) rd(ra[i], '1, '0, "reset value");
        $display("test reset done");
        for (int i = 0; i < 14; i++) begin
            min_voltage_strap       <= i < 2 ? 3'h0 : 3'($urandom % 8);
            max_voltage_strap       <= i < 2 ? 3'h4 + 3'(2 * i) : 3'($urandom);
            operating_current_strap <= i < 2 ? 3'h3 + 3'(2 * i) : 3'($urandom % 6);
            maximum_current_strap   <= i < 2 ? 3'h1 + 3'(2 * i) : 3'($urandom);
            repeat (3) @(posedge clk);
            look(min_power_cw, iop(operating_current_strap, maximum_current_strap) * vmin(min_voltage_strap), "minp");
            rd(`PSP_OFF_POWER, '1, {16'(iop(operating_current_strap, maximum_current_strap) * vmin(min_voltage_strap)),
               16'(imax(maximum_current_strap) * vmin(min_voltage_strap))}, "power");
            rd(`PSP_OFF_PDP, '1, {2{16'(imax(maximum_current_strap) * vmax(max_voltage_strap))}}, "pdp");
        end
        $display("test config done");
        cc_attached <= 1'h1;
        for (int i = 0; i < 20; i++) begin
            if (i == 10) begin
                operating_current_strap <= 3'h0;
                maximum_current_strap   <= 3'h3;
                min_voltage_strap       <= 3'h0;
            end
            o.valid   = $urandom % 8 != 0;
            o.volt_dv = vtab[$urandom % 5];
            o.curr_da = 6'($urandom % 51);
            offer(o);
        end
        o = {1'h1, vtab[0], 6'h01};
        offer(o);
        wr(`PSP_OFF_IRQ_MASK, 32'h1);
        wr(`PSP_OFF_IRQ_STAT, 32'hf);
        look(irq, 1'h0, "irq clear");
        offer('0);
        look(irq, 1'h1, "irq raised");
        wr(`PSP_OFF_IRQ_MASK, 32'h0);
        look(irq, 1'h0, "irq masked");
        wr(`PSP_OFF_IRQ_MASK, 32'h9);
        wr(`PSP_OFF_IRQ_STAT, 32'h1);
        look(irq, 1'h0, "irq w1c");
        fault_in <= 1'h1;
        @(posedge clk);
        look(pathv, 4'h2, "fault path");
        fault_in <= 1'h0;
        rd(`PSP_OFF_IRQ_STAT, 32'h8, 32'h8, "fault irq");
        look(irq, 1'h1, "fault irq pin");
        $display("test mismatch done");
        for (int k = 0; k < 6; k++) begin
            activity <= psp_act_t'(6'h1 << k);
            @(posedge clk);
            activity <= '0;
            repeat (5000) @(posedge clk);
            look(power_state, PSP_ACTIVE, "busy");
        end
        wait_st(PSP_IDLE, 10100);
        chk(32'(n > 4994 && n < 5004), 1, "idle delay");
        look(pathv, 4'he, "idle path");
        activity <= psp_act_t'(6'h1 << ($urandom % 6));
        @(posedge clk);
        activity <= '0;
        wait_st(PSP_ACTIVE, 3);
        wait_st(PSP_IDLE, 10100);
        wr(`PSP_OFF_CTRL, 32'h1);
        wait_st(PSP_STANDBY, 4);
        look(pathv, 4'h0, "standby path");
        wr(`PSP_OFF_CTRL, 32'h0);
        wait_st(PSP_IDLE, 4);
        cc_attached <= 1'h0;
        wait_st(PSP_SLEEP, 4);
        look(pathv, 4'h0, "sleep path");
        cc_attached <= 1'h1;
        wait_st(PSP_ACTIVE, 4);
        $display("test states done");
        temp_above_threshold <= 1'h1;
        repeat (3) @(posedge clk);
        temp_above_threshold <= 1'h0;
        repeat (4) @(posedge clk);
        look({shutdown_active, attach_indicator, pathv, power_state}, 8'h83, "hot");
        rd(`PSP_OFF_STATUS, 32'hff, 32'he1, "status hot");
        rd(`PSP_OFF_IRQ_STAT, 32'h6, 32'h6, "state thermal irq");
        temp_below_hysteresis <= 1'h1;
        repeat (2) @(posedge clk);
        temp_below_hysteresis <= 1'h0;
        look(shutdown_active, 1'h0, "cooled");
        wait_st(PSP_ACTIVE, 4);
        $display("test thermal done");
        main_3v3_supply_input <= 1'h1;
        for (int k = 0; k < 8; k++) begin
            cc_flipped <= k[0];
            cc_debug   <= k[1];
            wr(`PSP_OFF_CTRL, {30'h0, k[2], 1'h0});
            rd(`PSP_OFF_CTRL, '1, {30'h0, k[2], 1'h0}, "ctrl");
            look({vin_switch_enable, attach_indicator, orientation_indicator, debug_accessory_indicator},
                 {k[2], 1'h1, k[0], k[1]}, "pins");
        end
        main_3v3_supply_input <= 1'h0;
        @(posedge clk);
        look(vin_switch_enable, 1'h0, "no supply");
        $display("test pins done");
        complete_run();
    end
endmodule
